// >>> hw/sfb_top.sv
/*
  Spectral FIFO buffer: sample sequencer, 16-byte staging FIFO, byte pairing,
  256-byte entry RAM and the register port with its auto-wrapping pointer.
  Assumes the serial slave logic outside gives one-cycle load, read and write
  strobes on clk, and the measurement side gives one-cycle sample strobes.
*/
// Function
// - Channel five store bit set: write channel five as two bytes per sample.
// - Flicker detection on: channel five store bit ignored, no channel five data.
// - Select bits 5..1 enable channels four..zero, two bytes each.
// - Select bit 0 set: status byte stored, one byte per sample.
// - Config bit 7 set: raw flicker byte stored, one byte per sample.
// - Flicker detection off: flicker store bit ignored, no flicker byte.
// - Level register counts two-byte entries waiting, from 0 to 128.
// - Storage is a 256-byte RAM organised as two-byte entries.
// - Entry arriving while full sets overflow flag and is discarded.
// - Register pointer wraps from high data byte back to low data byte.
// - Read pointer advances and level drops by one when the high data byte is read with level above zero.
// - With level zero, data byte reads return zero.
`timescale 1ns/1ps

module sfb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sfb_fifo

////////////////////////////////////////////////////////////////////////////////

module sfb_top
  import sfb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_ptr_load,
  input wire logic [7:0] reg_ptr_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [7:0] reg_ptr,
  input wire logic sample_valid,
  output logic sample_busy,
  input wire logic [7:0] spectral_status_byte,
  input wire logic [15:0] chan_zero_data,
  input wire logic [15:0] chan_one_data,
  input wire logic [15:0] chan_two_data,
  input wire logic [15:0] chan_three_data,
  input wire logic [15:0] chan_four_data,
  input wire logic [15:0] chan_five_data,
  input wire logic [7:0] flicker_raw_data,
  input wire logic flicker_detect_on,
  output logic overflow_flag,
  input wire logic overflow_clear,
  output logic [7:0] buffer_entry_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and declarations
  logic [7:0] buffer_store_config;
  logic [7:0] fifo_channel_select;
  logic [15:0] entry_ram [ENTRY_DEPTH];
  logic [6:0] ram_wr_ptr;
  logic [6:0] ram_rd_ptr;
  sfb_seq_e seq_state;
  logic [2:0] item;
  logic half;
  logic [7:0] lat_en;
  logic [7:0] lat_status;
  logic [15:0] lat_chan [6];
  logic [7:0] lat_flicker;
  logic [7:0] next_en;
  logic [7:0] seq_byte;
  logic [3:0] first_hit;
  logic [3:0] next_hit;
  logic start;
  logic stage_in_ready;
  logic stage_push;
  logic stage_out_valid;
  logic stage_out_ready;
  logic [7:0] stage_out_data;
  logic stage_pop;
  logic asm_have;
  logic [7:0] asm_low;
  logic pair_done;
  logic entry_store;
  logic pop_now;
  logic [7:0] next_rdata;

  // Lowest enabled item at or after from; bit 3 marks a hit
  function automatic logic [3:0] find_item(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = ITEM_COUNT - 1; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : find_item

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_ptr <= ADDR_READ_LOW;
    end else if (reg_ptr_load) begin
      reg_ptr <= reg_ptr_addr;
    end else if (reg_rd || reg_wr) begin
      reg_ptr <= (reg_ptr == ADDR_READ_HIGH) ? ADDR_READ_LOW : reg_ptr + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer_store_config <= RST_STORE_CONFIG;
      fifo_channel_select <= RST_CHAN_SELECT;
    end else if (reg_wr && !reg_ptr_load) begin
      // Level and data bytes have no write path
      if (reg_ptr == ADDR_STORE_CONFIG) begin
        buffer_store_config <= reg_wdata;
      end
      if (reg_ptr == ADDR_CHAN_SELECT) begin
        fifo_channel_select <= reg_wdata & CHAN_SELECT_MASK;
      end
    end
  end

  assign pop_now = reg_rd && !reg_ptr_load && reg_ptr == ADDR_READ_HIGH && buffer_entry_count != 8'h00;

  always_comb begin
    next_rdata = 8'h00;
    case (reg_ptr)
      ADDR_STORE_CONFIG: next_rdata = buffer_store_config;
      ADDR_CHAN_SELECT: next_rdata = fifo_channel_select;
      ADDR_FILL_LEVEL: next_rdata = buffer_entry_count;
      ADDR_READ_LOW: next_rdata = (buffer_entry_count == 8'h00) ? 8'h00 : entry_ram[ram_rd_ptr][7:0];
      ADDR_READ_HIGH: next_rdata = (buffer_entry_count == 8'h00) ? 8'h00 : entry_ram[ram_rd_ptr][15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && !reg_ptr_load) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample sequencer
  always_comb begin
    next_en = 8'h00;
    next_en[BIT_STORE_STATUS] = fifo_channel_select[BIT_STORE_STATUS];
    next_en[5:1] = fifo_channel_select[5:1];
    next_en[ITEM_CHAN_FIVE] = fifo_channel_select[BIT_STORE_CHAN_FIVE] && !flicker_detect_on;
    next_en[ITEM_FLICKER] = buffer_store_config[BIT_STORE_FLICKER] && flicker_detect_on;
  end

  assign start = sample_valid && seq_state == SFB_SEQ_IDLE;
  assign sample_busy = seq_state == SFB_SEQ_RUN;
  assign first_hit = find_item(next_en, 4'h0);
  assign next_hit = find_item(lat_en, {1'b0, item} + 4'h1);
  assign stage_push = seq_state == SFB_SEQ_RUN && stage_in_ready;

  always_comb begin
    case (item)
      ITEM_STATUS: seq_byte = lat_status;
      ITEM_FLICKER: seq_byte = lat_flicker;
      default: seq_byte = half ? lat_chan[item - 3'h1][15:8] : lat_chan[item - 3'h1][7:0];
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_en <= 8'h00;
      lat_status <= 8'h00;
      lat_flicker <= 8'h00;
      lat_chan <= '{default: 16'h0000};
    end else if (start) begin
      lat_en <= next_en;
      lat_status <= spectral_status_byte;
      lat_flicker <= flicker_raw_data;
      lat_chan <= '{chan_zero_data, chan_one_data, chan_two_data, chan_three_data, chan_four_data, chan_five_data};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_state <= SFB_SEQ_IDLE;
      item <= ITEM_STATUS;
      half <= 1'b0;
    end else begin
      unique case (seq_state)
        SFB_SEQ_IDLE: begin
          if (start && first_hit[3]) begin
            seq_state <= SFB_SEQ_RUN;
            item <= first_hit[2:0];
            half <= 1'b0;
          end
        end
        SFB_SEQ_RUN: begin
          if (stage_push) begin
            if (item != ITEM_STATUS && item != ITEM_FLICKER && !half) begin
              half <= 1'b1;
            end else if (next_hit[3]) begin
              half <= 1'b0;
              item <= next_hit[2:0];
            end else begin
              half <= 1'b0;
              seq_state <= SFB_SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging FIFO and byte pairing
  sfb_fifo #(
    .WIDTH(STAGE_WIDTH),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk(clk),
    .rstn(rstn),
    .in_valid(seq_state == SFB_SEQ_RUN),
    .in_ready(stage_in_ready),
    .in_data(seq_byte),
    .out_valid(stage_out_valid),
    .out_ready(stage_out_ready),
    .out_data(stage_out_data)
  );

  // Drain waits while the host pops, so push and pop never meet
  assign stage_out_ready = !pop_now;
  assign stage_pop = stage_out_valid && stage_out_ready;
  assign pair_done = stage_pop && asm_have;
  assign entry_store = pair_done && buffer_entry_count != LEVEL_MAX;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asm_have <= 1'b0;
      asm_low <= 8'h00;
    end else if (stage_pop) begin
      asm_have <= !asm_have;
      if (!asm_have) begin
        asm_low <= stage_out_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry RAM, level and overflow
  always_ff @(posedge clk) begin
    if (entry_store) begin
      entry_ram[ram_wr_ptr] <= {stage_out_data, asm_low};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_wr_ptr <= 7'h00;
      ram_rd_ptr <= 7'h00;
      buffer_entry_count <= RST_FILL_LEVEL;
    end else begin
      if (entry_store) begin
        ram_wr_ptr <= ram_wr_ptr + 7'h01;
        buffer_entry_count <= buffer_entry_count + 8'h01;
      end
      if (pop_now) begin
        ram_rd_ptr <= ram_rd_ptr + 7'h01;
        buffer_entry_count <= buffer_entry_count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflow_flag <= 1'b0;
    end else if (pair_done && buffer_entry_count == LEVEL_MAX) begin
      overflow_flag <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_high;
    reg_rd && !reg_ptr_load && reg_ptr == ADDR_READ_HIGH;
  endsequence

  sequence s_read_low;
    reg_rd && !reg_ptr_load && reg_ptr == ADDR_READ_LOW;
  endsequence

  a_level_bound: assert property (buffer_entry_count <= LEVEL_MAX)
    else $error("level above maximum");
  a_ptr_wrap: assert property (s_read_high |=> reg_ptr == ADDR_READ_LOW)
    else $error("pointer did not wrap to low data byte");
  a_pop_level: assert property (s_read_high ##0 buffer_entry_count != 8'h00
      |=> buffer_entry_count == $past(buffer_entry_count) - 8'h01 && ram_rd_ptr == $past(ram_rd_ptr) + 7'h01)
    else $error("high byte read did not pop one entry");
  a_low_no_pop: assert property (s_read_low |=> $stable(ram_rd_ptr))
    else $error("low byte read moved read pointer");
  a_empty_zero: assert property (reg_rd && !reg_ptr_load && reg_ptr >= ADDR_READ_LOW && buffer_entry_count == 8'h00
      |=> reg_rdata == 8'h00)
    else $error("empty buffer read returned nonzero");
  a_write_ignored: assert property (reg_wr && !reg_ptr_load && reg_ptr >= ADDR_FILL_LEVEL
      |=> $stable(ram_rd_ptr) && buffer_entry_count >= $past(buffer_entry_count))
    else $error("write to read-only location changed buffer");
  a_overflow_set: assert property (pair_done && buffer_entry_count == LEVEL_MAX
      |=> overflow_flag && buffer_entry_count == LEVEL_MAX && $stable(ram_wr_ptr))
    else $error("overflow not flagged or entry not discarded");
  a_chan_five_gate: assert property (start && flicker_detect_on |=> !lat_en[ITEM_CHAN_FIVE])
    else $error("channel five enabled while flicker detection on");
  a_chan_map: assert property (start |=> lat_en[5:0] == $past(fifo_channel_select[5:0])
      && lat_en[ITEM_CHAN_FIVE] == ($past(fifo_channel_select[6]) && !$past(flicker_detect_on)))
    else $error("channel enables not taken from select register");
  a_flicker_gate: assert property (start |=> lat_en[ITEM_FLICKER]
      == ($past(buffer_store_config[BIT_STORE_FLICKER]) && $past(flicker_detect_on)))
    else $error("flicker enable wrong");
  a_item_order: assert property (seq_state == SFB_SEQ_RUN ##1 seq_state == SFB_SEQ_RUN |-> item >= $past(item))
    else $error("items out of order");
  a_pair_bytes: assert property (stage_push && half |=> !half && item != ITEM_STATUS)
    else $error("two-byte item not completed");

endmodule : sfb_top

// >>> hw/sfb_pkg.sv
/*
  Constants for the spectral FIFO buffer: register offsets, field positions,
  reset values, sizes and the sequencer state type.
  Assumes an 8-bit register port whose address pointer lives in the block.
*/
package sfb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_STORE_CONFIG = 8'hDF;
  localparam logic [7:0] ADDR_CHAN_SELECT = 8'hFC;
  localparam logic [7:0] ADDR_FILL_LEVEL = 8'hFD;
  localparam logic [7:0] ADDR_READ_LOW = 8'hFE;
  localparam logic [7:0] ADDR_READ_HIGH = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and field layout
  localparam logic [7:0] RST_STORE_CONFIG = 8'h21;
  localparam logic [7:0] RST_CHAN_SELECT = 8'h00;
  localparam logic [7:0] RST_FILL_LEVEL = 8'h00;
  localparam logic [7:0] CHAN_SELECT_MASK = 8'h7F;
  localparam int BIT_STORE_STATUS = 0;
  localparam int BIT_STORE_CHAN_FIVE = 6;
  localparam int BIT_STORE_FLICKER = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Item order within one sample
  localparam logic [2:0] ITEM_STATUS = 3'h0;
  localparam logic [2:0] ITEM_CHAN_FIVE = 3'h6;
  localparam logic [2:0] ITEM_FLICKER = 3'h7;
  localparam int ITEM_COUNT = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int RAM_BYTES = 256;
  localparam int ENTRY_BYTES = 2;
  localparam int ENTRY_DEPTH = RAM_BYTES / ENTRY_BYTES;
  localparam logic [7:0] LEVEL_MAX = 8'h80;
  localparam int STAGE_WIDTH = 8;
  localparam int STAGE_DEPTH = 16;

  typedef enum logic {
    SFB_SEQ_IDLE,
    SFB_SEQ_RUN
  } sfb_seq_e;

endpackage : sfb_pkg

// >>> testbench/sfb_host_model.sv
/*
  Host side of the register port: loads the pointer, then reads or writes at it.
  Assumes the block takes each strobe on the rising edge of clk.
*/
`timescale 1ns/1ps

module sfb_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_ptr_load,
  output logic [7:0] reg_ptr_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial begin
    reg_ptr_load = 1'b0;
    reg_ptr_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic point(input logic [7:0] addr);
    @(negedge clk);
    reg_ptr_load = 1'b1;
    reg_ptr_addr = addr;
    @(negedge clk);
    reg_ptr_load = 1'b0;
    reg_ptr_addr = ~addr;
  endtask : point

  task automatic read_next(output logic [7:0] data);
    @(negedge clk);
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    data = reg_rdata;
  endtask : read_next

  // Released data shows the inverse so stale values never match
  task automatic write_next(input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask : write_next
endmodule : sfb_host_model

// >>> testbench/testbench.sv
/*
  Self-checking bench for sfb_top: register reads, sample packing, read-only
  writes, channel order and overflow.
  Assumes sfb_host_model drives the register port.
*/
`timescale 1ns/1ps

module testbench
  import sfb_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_ptr_load, reg_wr, reg_rd, sample_valid = 1'b0, sample_busy;
  logic flicker_detect_on = 1'b0, overflow_flag, overflow_clear = 1'b0;
  logic [7:0] reg_ptr_addr, reg_wdata, reg_rdata, reg_ptr, buffer_entry_count;
  logic [7:0] stat = 8'h5A;
  logic [7:0] flick = 8'hC3;
  logic [15:0] ch [6];
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  sfb_host_model sfb_host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_ptr_load(reg_ptr_load),
    .reg_ptr_addr(reg_ptr_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  sfb_top sfb_top_inst (.clk(clk), .rstn(rstn), .reg_ptr_load(reg_ptr_load), .reg_ptr_addr(reg_ptr_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr),
    .sample_valid(sample_valid), .sample_busy(sample_busy), .spectral_status_byte(stat),
    .chan_zero_data(ch[0]), .chan_one_data(ch[1]), .chan_two_data(ch[2]), .chan_three_data(ch[3]),
    .chan_four_data(ch[4]), .chan_five_data(ch[5]), .flicker_raw_data(flick),
    .flicker_detect_on(flicker_detect_on), .overflow_flag(overflow_flag), .overflow_clear(overflow_clear),
    .buffer_entry_count(buffer_entry_count));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] d);
    sfb_host_model_inst.point(addr);
    sfb_host_model_inst.read_next(d);
  endtask : reg_read

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] d);
    sfb_host_model_inst.point(addr);
    sfb_host_model_inst.write_next(d);
  endtask : reg_write

  task automatic pulse(input int pad);
    @(negedge clk);
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    for (int i = 0; i < 40 && sample_busy !== 1'b0; i++) @(negedge clk);
    repeat (pad) @(negedge clk);
  endtask : pulse

  task automatic sample(input logic [7:0] sel, input logic [7:0] cfg, input logic fd);
    reg_write(ADDR_CHAN_SELECT, sel);
    reg_write(ADDR_STORE_CONFIG, cfg);
    flicker_detect_on = fd;
    pulse(20);
  endtask : sample

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    check(reg_ptr, 8'hFE);
    check({7'h00, overflow_flag}, 8'h00);
    reg_read(ADDR_STORE_CONFIG, d);
    check(d, RST_STORE_CONFIG);
    reg_read(ADDR_CHAN_SELECT, d);
    check(d, 8'h00);
    reg_read(ADDR_FILL_LEVEL, d);
    check(d, 8'h00);
    reg_read(ADDR_READ_HIGH, d);
    check(d, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_order;
    logic [7:0] d;
    logic [7:0] exp [6];
    exp = '{stat, ch[0][7:0], ch[0][15:8], flick, ch[5][7:0], ch[5][15:8]};
    sample(8'h03, 8'h21, 1'b0);
    sample(8'h40, 8'hA1, 1'b1);
    sample(8'h40, 8'hA1, 1'b0);
    check(buffer_entry_count, 8'h03);
    sfb_host_model_inst.point(ADDR_READ_LOW);
    for (int i = 0; i < 6; i++) begin
      sfb_host_model_inst.read_next(d);
      check(d, exp[i]);
      check(buffer_entry_count, 8'(3 - (i + 1) / 2));
    end
    check(reg_ptr, ADDR_READ_LOW);
    sfb_host_model_inst.read_next(d);
    check(d, 8'h00);
    $display("test order done");
  endtask : t_order

  task automatic t_readonly;
    logic [7:0] d;
    sample(8'h02, 8'h21, 1'b0);
    sfb_host_model_inst.point(ADDR_FILL_LEVEL);
    for (int i = 0; i < 3; i++) sfb_host_model_inst.write_next(8'h00);
    check(buffer_entry_count, 8'h01);
    reg_read(ADDR_READ_LOW, d);
    check(d, ch[0][7:0]);
    sfb_host_model_inst.read_next(d);
    check(d, ch[0][15:8]);
    reg_read(8'h10, d);
    check(d, 8'h00);
    reg_write(ADDR_CHAN_SELECT, 8'hFF);
    reg_read(ADDR_CHAN_SELECT, d);
    check(d, CHAN_SELECT_MASK);
    $display("test readonly done");
  endtask : t_readonly

  task automatic t_channels;
    logic [7:0] d;
    sample(8'h3E, 8'h21, 1'b0);
    check(buffer_entry_count, 8'h05);
    sfb_host_model_inst.point(ADDR_READ_LOW);
    for (int i = 0; i < 10; i++) begin
      sfb_host_model_inst.read_next(d);
      check(d, i[0] ? ch[i / 2][15:8] : ch[i / 2][7:0]);
    end
    $display("test channels done");
  endtask : t_channels

  task automatic t_overflow;
    logic [7:0] d;
    reg_write(ADDR_CHAN_SELECT, 8'h02);
    for (int i = 0; i < 129; i++) begin
      ch[0] = 16'(i);
      pulse(4);
    end
    check(buffer_entry_count, LEVEL_MAX);
    check({7'h00, overflow_flag}, 8'h01);
    reg_read(ADDR_READ_LOW, d);
    check(d, 8'h00);
    overflow_clear = 1'b1;
    @(negedge clk);
    overflow_clear = 1'b0;
    @(negedge clk);
    check({7'h00, overflow_flag}, 8'h00);
    $display("test overflow done");
  endtask : t_overflow

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      final_report;
    end
  end

  initial begin
    for (int k = 0; k < 6; k++) ch[k] = 16'h1020 + 16'h0303 * 16'(k);
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_order;
    t_readonly;
    t_channels;
    t_overflow;
    final_report;
  end
endmodule : testbench
